// [bench/tape_head_model.sv]
// Read head and amplifier model that plays characters onto the pins.
module tape_head_model (
  input wire logic clk, // System clock used for pacing.
  output logic [6:0] amp_pulse // Peak pulses, idle low.
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins rest low, as an amplifier with no signal does.
  initial amp_pulse = 7'h00;
  // Raise the chosen channels, then drop them together; the fall marks the peak.
  task automatic emit(input logic [6:0] pat);
    @(posedge clk);
    amp_pulse <= pat;
    repeat (50) @(posedge clk);
    amp_pulse <= 7'h00;
  endtask
endmodule

// [bench/tb_tape_read_frame.sv]
// Self-checking testbench for the tape read framing block.
module tb_tape_read_frame;
  import tape_read_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0; // System clock.
  logic sys_rst = 1'b1; // Reset, held at start.
  logic [7:0] address = 8'h00; // Bus address.
  logic read = 1'b0; // Bus read.
  logic write = 1'b0; // Bus write.
  logic [31:0] writedata = 32'h0; // Bus write data.
  logic [31:0] readdata; // Bus read data.
  logic waitrequest; // Bus stall.
  logic [NCH-1:0] amp_pulse; // Pins from the head model.
  logic [NCH-1:0] host_char; // Character out.
  logic host_char_strobe; // Character strobe.
  logic char_detect_clock; // Detect clock.
  logic char_gate_read; // Gate read.
  logic wq; // Stall as it stands before the next rising edge.
  logic [31:0] rq; // Read data as it stands before the next rising edge.
  int err_count = 0; // Mismatches.
  int num_checks = 0; // Comparisons.
  logic [31:0] q; // Scratch read result.
  tape_read_frame u_dut (.clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .amp_pulse(amp_pulse), .host_char(host_char), .host_char_strobe(host_char_strobe),
    .char_detect_clock(char_detect_clock), .char_gate_read(char_gate_read));
  tape_head_model u_head (.clk(clk), .amp_pulse(amp_pulse));
  // Clock at 100 MHz.
  initial forever #5 clk = ~clk;
  // Sample at the falling edge so the rising edge never races with the design.
  always @(negedge clk) begin
    wq <= waitrequest;
    rq <= readdata;
  end
  // Compare and count.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One Avalon transfer, held until the edge where the stall is seen low.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    do @(posedge clk); while (wq !== 1'b0);
    r = rq;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // Play one character and count the strobes; the last strobed value is judged.
  // The cycles of detect clock and gate read are counted against the density's periods.
  task automatic send_char(input logic [6:0] pat, input logic [6:0] exp, input int n_exp,
                           input logic [CNT_W-1:0] cf_exp, input logic [CNT_W-1:0] cr_exp);
    int n;
    int cf_n;
    int cr_n;
    logic [6:0] seen;
    n = 0;
    cf_n = 0;
    cr_n = 0;
    seen = 7'h00;
    u_head.emit(pat);
    repeat (3000) begin
      @(negedge clk);
      if (host_char_strobe === 1'b1) begin
        n++;
        seen = host_char;
      end
      if (char_detect_clock === 1'b1) cf_n++;
      if (char_gate_read === 1'b1) cr_n++;
    end
    chk(n, n_exp);
    if (n_exp > 0) chk(seen, exp);
    chk(cf_n, 32'(cf_exp));
    chk(cr_n, 32'(cr_exp));
  endtask
  // Verdict and end of run.
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Watchdog sized well beyond the seven characters of the run.
  initial begin
    #400000;
    err_count++;
    wrap_up();
  end
  // Values after reset and an unmapped read.
  task automatic t_idle();
    bus(1'b0, CTRL_OFS, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b0, 8'h30, 32'h0, q);
    chk(q, 32'h0);
  endtask
  // Deskew periods reset mid-range, and writes outside the span are clamped.
  task automatic t_delays();
    bus(1'b0, 8'h44, 32'h0, q);
    chk(q, 32'(DSK_RST_CYC));
    bus(1'b1, 8'h40, 32'd200, q); // Shortest delay on channel 0 splits the bit falls.
    bus(1'b1, 8'h60, 32'h7ff, q);
    bus(1'b0, 8'h60, 32'h0, q);
    chk(q, 32'(DSK_MAX_CYC));
    bus(1'b1, 8'h78, 32'h1, q);
    bus(1'b0, 8'h78, 32'h0, q);
    chk(q, 32'(DSK_MIN_CYC));
  endtask
  // Plain read; direction and test stay put while a character is framed.
  task automatic t_read();
    bus(1'b1, CTRL_OFS, 32'h10d, q);
    bus(1'b0, CTRL_OFS, 32'h0, q);
    chk(q, 32'h10d);
    send_char(7'h03, 7'h03, 1, CF_C_CYC, CR_C_CYC);
  endtask
  // Coded read mode swaps the zero and blank codes.
  task automatic t_bcd();
    bus(1'b1, CTRL_OFS, 32'h14d, q);
    send_char(7'h4a, 7'h40, 1, CF_C_CYC, CR_C_CYC);
    bus(1'b1, CTRL_OFS, 32'h10d, q);
  endtask
  // In the gap nothing frames, unless the check window is open.
  task automatic t_gap();
    bus(1'b1, GAP_OFS, 32'h1, q);
    send_char(7'h7f, 7'h00, 0, '0, '0);
    bus(1'b1, GAP_OFS, 32'h5, q);
    send_char(7'h11, 7'h11, 1, CF_C_CYC, CR_C_CYC);
    bus(1'b1, GAP_OFS, 32'h0, q);
  endtask
  // Reverse tape motion, then the buffer and parity registers.
  task automatic t_reverse();
    bus(1'b1, CTRL_OFS, 32'h115, q);
    send_char(7'h22, 7'h22, 1, CF_C_CYC, CR_C_CYC);
    bus(1'b0, STAT_OFS, 32'h0, q);
    chk(q[22:16], 7'h7a);
    chk(q[14:8], 7'h22);
  endtask
  // Write checking at the middle density: bits toggle the hold flops, no transfer.
  task automatic t_write_check();
    bus(1'b1, CTRL_OFS, 32'h08f, q);
    send_char(7'h03, 7'h00, 0, CF_B_CYC, '0);
    send_char(7'h01, 7'h00, 0, CF_B_CYC, '0);
    bus(1'b0, STAT_OFS, 32'h0, q);
    chk(q[6:0], 7'h02);
  endtask
  // Motion start clears the framing state.
  task automatic t_start();
    bus(1'b1, CMD_OFS, 32'h1, q);
    bus(1'b0, STAT_OFS, 32'h0, q);
    chk(q[24:16], 9'h000);
    chk(q[6:0], 7'h00);
  endtask
  // Main sequence.
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    t_idle();
    t_delays();
    t_read();
    t_bcd();
    t_gap();
    t_reverse();
    t_write_check();
    t_start();
    wrap_up();
  end
endmodule

// [rtl/one_shot.sv]
// Programmable one-shot realised as a down-counter on the system clock.
module one_shot
  import tape_read_pkg::*;
#(
  parameter int W = CNT_W
) (
  input wire logic clk, // System clock.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire logic trig, // Start pulse, one cycle.
  input wire logic hold, // Static hold, forces the timer idle.
  input wire logic [W-1:0] load, // Period in clock cycles.
  output logic active // High while the period runs.
);

  logic [W-1:0] count; // Cycles left in the period.

  // A hold beats a trigger, so a held timer never starts.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
    end else if (hold) begin
      count <= '0;
    end else if (trig) begin
      count <= load;
    end else if (count != '0) begin
      count <= count - W'(1);
    end
  end

  // The output is a plain decode of the counter flop.
  assign active = (count != '0);

endmodule

// [rtl/tape_read_frame.sv]
// Read-side deskew, first-bit lockout and character clocks of a tape controller.
//
// Summary of operation
// - Reading runs in both read and write checking.
// - Amplifier pulse triggers forward or reverse timer.
// - Timer delay per channel, 2 to 8 us.
// - Reverse or test holds forward timers static.
// - Forward or test holds reverse timers static.
// - Deskewed bit is forward OR reverse output.
// - Bits set hold flops reading, toggle writing.
// - Held char toggles parity, copied to buffer.
// - Buffer translated in BCD, passed in binary.
// - First-bit sense ORs falls, gated by lockout.
// - Lockout sets on sense, blocks later bits.
// - Gap or load point inhibits, except check window.
// - Lockout clears on gate read, write clock, start.
// - Lockout fires density-selected detect clock.
// - Raw detect clock qualified before use.
// - Gate read starts when detect clock ends, reading only.
module tape_read_frame
  import tape_read_pkg::*;
(
  input wire logic clk, // System clock, 100 MHz.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire logic [7:0] address, // Avalon byte address.
  input wire logic read, // Avalon read request.
  input wire logic write, // Avalon write request.
  input wire logic [31:0] writedata, // Avalon write data.
  output logic [31:0] readdata, // Avalon read data, registered.
  output logic waitrequest, // Avalon stall, high until answered.
  input wire logic [NCH-1:0] amp_pulse, // Peak-detected amplifier pins.
  output logic [NCH-1:0] host_char, // Translated character, registered.
  output logic host_char_strobe, // One-cycle pulse with a new character.
  output logic char_detect_clock, // Qualified detect clock, registered.
  output logic char_gate_read // Gate read level, registered.
);

  // Control register state.
  logic [8:0] ctrl; // Mode, direction and density bits.
  logic [2:0] gap; // Gap, load point and check window.
  logic [NCH-1:0] test_bits; // Test signals per channel.
  logic motion_start; // Direct start reset, one cycle.
  logic ack; // Bus answer cycle.
  logic [CNT_W-1:0] fwd_delay [NCH]; // Forward deskew periods.
  logic [CNT_W-1:0] rev_delay [NCH]; // Reverse deskew periods.

  // Decoded controls.
  logic tape_op_active; // Operation in progress.
  logic transfer_direction_flag; // High while writing.
  logic tape_motion_active; // Tape is moving.
  logic forward_motion; // Forward direction.
  logic reverse_motion; // Reverse direction.
  logic test_mode; // Test signals drive outputs.
  logic gap_timer_flag; // Crossing an inter-record gap.
  logic check_char_window; // Check character expected.
  density_t density; // Selected density.
  logic reading; // Read operation.
  logic writing; // Write operation with read-back.

  assign tape_op_active = ctrl[C_OP];
  assign transfer_direction_flag = ctrl[C_DIR];
  assign tape_motion_active = ctrl[C_MOT];
  assign forward_motion = ctrl[C_FWD];
  assign reverse_motion = ctrl[C_REV];
  assign test_mode = ctrl[C_TEST];
  assign density = density_t'(ctrl[C_DENS +: 2]);
  assign gap_timer_flag = gap[G_GAP];
  assign check_char_window = gap[G_CHK];
  assign reading = tape_op_active & ~transfer_direction_flag;
  assign writing = tape_op_active & transfer_direction_flag;

  // Bus answer: every request waits exactly one cycle.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (read | write) & ~ack;
    end
  end

  assign waitrequest = (read | write) & ~ack;

  // Writes land only on the edge that sees waitrequest low.
  logic wr_take; // Write accepted this edge.
  logic [2:0] bank; // Deskew bank select.
  logic [2:0] chan; // Deskew channel select.
  logic [CNT_W-1:0] wr_delay; // Clamped delay value.

  assign wr_take = write & ack;
  assign bank = address[7:5];
  assign chan = address[4:2];

  // Software values outside the calibration range are clamped.
  always_comb begin
    wr_delay = writedata[CNT_W-1:0];
    if (wr_delay < DSK_MIN_CYC) begin
      wr_delay = DSK_MIN_CYC;
    end else if (wr_delay > DSK_MAX_CYC) begin
      wr_delay = DSK_MAX_CYC;
    end
  end

  // Control, gap and test registers.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= CTRL_RST;
      gap <= GAP_RST;
      test_bits <= '0;
    end else if (wr_take) begin
      if (address == CTRL_OFS) begin
        ctrl <= writedata[8:0];
      end
      if (address == GAP_OFS) begin
        gap <= writedata[2:0];
      end
      if (address == TEST_OFS) begin
        test_bits <= writedata[NCH-1:0];
      end
    end
  end

  // Motion start is a self-clearing command bit.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      motion_start <= 1'b0;
    end else begin
      motion_start <= wr_take & (address == CMD_OFS) & writedata[0];
    end
  end

  // Per-channel synchronisers, timers and deskew delay registers.
  logic [NCH-1:0] fwd_out; // Forward timer outputs.
  logic [NCH-1:0] rev_out; // Reverse timer outputs.
  logic [NCH-1:0] deskewed_bit; // Combined channel output.
  logic [NCH-1:0] deskewed_q; // Previous deskewed value.
  logic [NCH-1:0] bit_fall; // Falling edge per channel.
  logic hold_fwd; // Forward timers held static.
  logic hold_rev; // Reverse timers held static.

  assign hold_fwd = tape_motion_active & (reverse_motion | test_mode);
  assign hold_rev = tape_motion_active & (forward_motion | test_mode);

  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      logic s1; // First stage, read only by s2.
      logic s2; // Second stage.
      logic s3; // Third stage.
      logic filt; // Accepted pin level.
      logic trig; // Fall of the accepted level.

      // The pin passes three flops; a change counts when s2 and s3 agree.
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          filt <= 1'b0;
        end else begin
          s1 <= amp_pulse[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            filt <= s3;
          end
        end
      end

      // The amplifier marks a peak by the fall of its output.
      // The fall counts only once both late stages agree, and for one cycle only.
      assign trig = filt & ~s2 & ~s3;

      // Deskew periods reset mid-range and stay in range.
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          fwd_delay[i] <= DSK_RST_CYC;
          rev_delay[i] <= DSK_RST_CYC;
        end else if (wr_take && chan == 3'(i)) begin
          if (bank == FWD_BANK) begin
            fwd_delay[i] <= wr_delay;
          end
          if (bank == REV_BANK) begin
            rev_delay[i] <= wr_delay;
          end
        end
      end

      // The held timer of the unused direction cannot fire.
      one_shot u_fwd (
        .clk(clk),
        .sys_rst(sys_rst),
        .trig(trig),
        .hold(hold_fwd),
        .load(fwd_delay[i]),
        .active(fwd_out[i])
      );

      one_shot u_rev (
        .clk(clk),
        .sys_rst(sys_rst),
        .trig(trig),
        .hold(hold_rev),
        .load(rev_delay[i]),
        .active(rev_out[i])
      );

      // Test signals are wired into the same OR as the timers.
      assign deskewed_bit[i] = fwd_out[i] | rev_out[i] | (test_mode & test_bits[i]);
    end
  endgenerate

  // Deskewed bits are on this clock, so edges need no synchroniser.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      deskewed_q <= '0;
    end else begin
      deskewed_q <= deskewed_bit;
    end
  end

  assign bit_fall = deskewed_q & ~deskewed_bit;

  // First-bit sense and its lockout flop.
  logic lockout; // First-bit lockout flop.
  logic first_bit_sense; // Any fall while unlocked.
  logic sense_allow; // Gap and load point qualification.
  logic lock_set; // Lockout sets this edge.
  logic lock_clr; // Lockout clears this edge.
  logic cf_prev; // Detect clock one cycle ago.

  assign first_bit_sense = (|bit_fall) & ~lockout;
  // Both read and write checking use the same gate.
  assign sense_allow = (tape_op_active & ~gap_timer_flag & ~gap[G_LOAD])
                     | check_char_window;
  assign lock_set = first_bit_sense & sense_allow;
  // While writing, the lockout clears at the end of the detect period, not at its
  // start, so that late bits of the same character cannot start a second period.
  assign lock_clr = char_gate_read | (cf_prev & ~char_detect_clock & writing);

  // Start reset dominates; otherwise a set beats a clear in the same cycle.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lockout <= 1'b0;
    end else if (motion_start) begin
      lockout <= 1'b0;
    end else if (lock_set) begin
      lockout <= 1'b1;
    end else if (lock_clr) begin
      lockout <= 1'b0;
    end
  end

  // Density-selected periods; detect and gate read each run their own counter.
  logic [CNT_W-1:0] cf_load; // Detect period.
  logic [CNT_W-1:0] cr_load; // Gate read period.
  logic dens_ok; // A real density is chosen.

  always_comb begin
    cf_load = '0;
    cr_load = '0;
    dens_ok = 1'b1;
    unique case (density)
      DENS_A: begin
        cf_load = CF_A_CYC;
        cr_load = CR_A_CYC;
      end
      DENS_B: begin
        cf_load = CF_B_CYC;
        cr_load = CR_B_CYC;
      end
      DENS_C: begin
        cf_load = CF_C_CYC;
        cr_load = CR_C_CYC;
      end
      DENS_NONE: begin
        dens_ok = 1'b0;
      end
    endcase
  end

  // Raw detect clock from the selected timer.
  logic cf_raw; // Unqualified detect clock.
  logic dens_stable; // Density unchanged since last cycle.
  density_t density_q; // Density one cycle ago.

  one_shot u_cf (
    .clk(clk),
    .sys_rst(sys_rst),
    .trig(lock_set & dens_ok),
    .hold(motion_start),
    .load(cf_load),
    .active(cf_raw)
  );

  // A switch of density masks the clock so no false pulse escapes.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      density_q <= DENS_NONE;
      char_detect_clock <= 1'b0;
    end else begin
      density_q <= density;
      char_detect_clock <= cf_raw & dens_stable;
    end
  end

  assign dens_stable = (density == density_q);

  // Gate read starts when the qualified detect clock times out during a read operation.
  logic cf_fall; // Detect clock just ended.
  logic cr_raw; // Unqualified gate read.

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cf_prev <= 1'b0;
    end else begin
      cf_prev <= char_detect_clock;
    end
  end

  assign cf_fall = cf_prev & ~char_detect_clock & reading;

  one_shot u_cr (
    .clk(clk),
    .sys_rst(sys_rst),
    .trig(cf_fall),
    .hold(motion_start),
    .load(cr_load),
    .active(cr_raw)
  );

  // The start reset also masks the gate.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      char_gate_read <= 1'b0;
    end else begin
      char_gate_read <= cr_raw & ~motion_start;
    end
  end

  // Transfer pulse at the start of gate read, and the flop reset after it.
  logic gate_prev; // Gate read one cycle ago.
  logic xfer; // Buffer transfer pulse.
  logic cri_active; // Read flop reset window.

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gate_prev <= 1'b0;
    end else begin
      gate_prev <= char_gate_read;
    end
  end

  assign xfer = char_gate_read & ~gate_prev & reading;

  one_shot u_cri (
    .clk(clk),
    .sys_rst(sys_rst),
    .trig(xfer),
    .hold(motion_start),
    .load(CRI_CYC),
    .active(cri_active)
  );

  // Read hold flops: set when reading, toggle when checking a write.
  logic [NCH-1:0] read_hold_flop; // Character being assembled.

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      read_hold_flop <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (motion_start) begin
          read_hold_flop[c] <= 1'b0;
        end else if (bit_fall[c] && sense_allow) begin
          // A bit beats the reset window for one cycle; the window clears it again while it runs.
          read_hold_flop[c] <= writing ? ~read_hold_flop[c] : 1'b1;
        end else if (cri_active) begin
          read_hold_flop[c] <= 1'b0;
        end
      end
    end
  end

  // Buffer and longitudinal parity registers take the held character.
  logic [NCH-1:0] buffer_register_bit; // One extra character.
  logic [NCH-1:0] write_data_register_bit; // Parity accumulator.

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      buffer_register_bit <= '0;
      write_data_register_bit <= '0;
    end else if (motion_start) begin
      buffer_register_bit <= '0;
      write_data_register_bit <= '0;
    end else if (xfer) begin
      buffer_register_bit <= read_hold_flop;
      write_data_register_bit <= write_data_register_bit ^ read_hold_flop;
    end
  end

  // Interchange code writes zero as 001010 and blank as 000000;
  // the internal code swaps them. Parity passes through.
  function automatic logic [NCH-1:0] translate(input logic [NCH-1:0] v, input logic bcd);
    logic [NCH-1:0] r;
    r = v;
    if (bcd && v[5:0] == 6'h0a) begin
      r[5:0] = 6'h00;
    end else if (bcd && v[5:0] == 6'h00) begin
      r[5:0] = 6'h0a;
    end
    return r;
  endfunction

  // The translated character follows the buffer load by one cycle.
  logic [NCH-1:0] translated_bit; // Translation output.
  logic xfer_q; // Transfer one cycle ago.

  assign translated_bit = translate(buffer_register_bit, ctrl[C_BCD]);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xfer_q <= 1'b0;
      host_char <= '0;
      host_char_strobe <= 1'b0;
    end else begin
      xfer_q <= xfer;
      host_char_strobe <= xfer_q;
      if (xfer_q) begin
        host_char <= translated_bit;
      end
    end
  end

  // Read data mux; unmapped addresses read as zero.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      readdata <= '0;
    end else if (read & ~ack) begin
      readdata <= '0;
      if (address == CTRL_OFS) begin
        readdata[8:0] <= ctrl;
      end else if (address == GAP_OFS) begin
        readdata[2:0] <= gap;
      end else if (address == TEST_OFS) begin
        readdata[NCH-1:0] <= test_bits;
      end else if (address == STAT_OFS) begin
        readdata <= {5'h00, char_gate_read, char_detect_clock, lockout,
                     1'b0, write_data_register_bit, 1'b0, buffer_register_bit,
                     1'b0, read_hold_flop};
      end else if (address == CHAR_OFS) begin
        readdata[NCH-1:0] <= host_char;
      end else if (bank == FWD_BANK && chan < 3'(NCH)) begin
        readdata[CNT_W-1:0] <= fwd_delay[chan];
      end else if (bank == REV_BANK && chan < 3'(NCH)) begin
        readdata[CNT_W-1:0] <= rev_delay[chan];
      end
    end
  end

  // Checks on the framing logic.
  property p_fwd_held;
    @(posedge clk) disable iff (sys_rst) hold_fwd |=> fwd_out == '0;
  endproperty
  a_fwd_held: assert property (p_fwd_held) else $error("forward timer ran while held");

  property p_rev_held;
    @(posedge clk) disable iff (sys_rst) hold_rev |=> rev_out == '0;
  endproperty
  a_rev_held: assert property (p_rev_held) else $error("reverse timer ran while held");

  // A hold seen on the previous edge has already emptied the forward timers.
  property p_or_bits;
    @(posedge clk) disable iff (sys_rst)
      (hold_fwd && $past(hold_fwd) && !test_mode) |-> deskewed_bit == rev_out;
  endproperty
  a_or_bits: assert property (p_or_bits) else $error("deskewed bit not reverse output");

  property p_range;
    @(posedge clk) disable iff (sys_rst)
      (fwd_delay[0] >= DSK_MIN_CYC) && (fwd_delay[0] <= DSK_MAX_CYC) &&
      (rev_delay[0] >= DSK_MIN_CYC) && (rev_delay[0] <= DSK_MAX_CYC);
  endproperty
  a_range: assert property (p_range) else $error("deskew delay out of range");

  // A bit that falls while locked out must not start a new detect period.
  property p_sense_gate;
    @(posedge clk) disable iff (sys_rst) (lockout && |bit_fall) |=> !$rose(cf_raw);
  endproperty
  a_sense_gate: assert property (p_sense_gate) else $error("restart while locked");

  property p_lock_set;
    @(posedge clk) disable iff (sys_rst)
      (|bit_fall && !lockout && sense_allow && !motion_start) |=> lockout;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lockout did not set");

  property p_gap_block;
    @(posedge clk) disable iff (sys_rst) (!lockout && !sense_allow) |=> !lockout;
  endproperty
  a_gap_block: assert property (p_gap_block) else $error("lockout set across gap");

  property p_start_clr;
    @(posedge clk) disable iff (sys_rst) motion_start |=> !lockout && !char_gate_read;
  endproperty
  a_start_clr: assert property (p_start_clr) else $error("start reset ignored");

  property p_cf_fire;
    @(posedge clk) disable iff (sys_rst)
      (lock_set && dens_ok && !motion_start) ##1 dens_stable |=> char_detect_clock;
  endproperty
  a_cf_fire: assert property (p_cf_fire) else $error("detect clock not fired");

  property p_buffer;
    @(posedge clk) disable iff (sys_rst)
      (xfer && !motion_start) |=> buffer_register_bit == $past(read_hold_flop) ##1 host_char_strobe;
  endproperty
  a_buffer: assert property (p_buffer) else $error("buffer transfer wrong");

endmodule

// [rtl/tape_read_pkg.sv]
// Shared constants for the tape read character framing block.
package tape_read_pkg;

  // Clock period in nanoseconds at 100 MHz.
  localparam int CLK_NS = 10;

  // Number of tape channels: six data bits plus parity.
  localparam int NCH = 7;

  // Width of every one-shot down-counter.
  localparam int CNT_W = 11;

  // Deskew delay limits, in nanoseconds as printed.
  localparam int DSK_MIN_NS = 2000;
  localparam int DSK_MAX_NS = 8000;
  localparam int DSK_RST_NS = 5000;

  // Least time rounds up, longest time rounds down.
  localparam logic [CNT_W-1:0] DSK_MIN_CYC = CNT_W'((DSK_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] DSK_MAX_CYC = CNT_W'(DSK_MAX_NS / CLK_NS);
  localparam logic [CNT_W-1:0] DSK_RST_CYC = CNT_W'(DSK_RST_NS / CLK_NS);

  // Character detect periods per density, in nanoseconds.
  localparam int CF_A_NS = 12000;
  localparam int CF_B_NS = 5000;
  localparam int CF_C_NS = 3000;

  // Character gate read periods per density, in nanoseconds.
  localparam int CR_A_NS = 17000;
  localparam int CR_B_NS = 6000;
  localparam int CR_C_NS = 4000;

  // Read flop reset pulse after a buffer transfer.
  localparam int CRI_NS = 500;

  localparam logic [CNT_W-1:0] CF_A_CYC = CNT_W'(CF_A_NS / CLK_NS);
  localparam logic [CNT_W-1:0] CF_B_CYC = CNT_W'(CF_B_NS / CLK_NS);
  localparam logic [CNT_W-1:0] CF_C_CYC = CNT_W'(CF_C_NS / CLK_NS);
  localparam logic [CNT_W-1:0] CR_A_CYC = CNT_W'(CR_A_NS / CLK_NS);
  localparam logic [CNT_W-1:0] CR_B_CYC = CNT_W'(CR_B_NS / CLK_NS);
  localparam logic [CNT_W-1:0] CR_C_CYC = CNT_W'(CR_C_NS / CLK_NS);
  localparam logic [CNT_W-1:0] CRI_CYC = CNT_W'(CRI_NS / CLK_NS);

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] GAP_OFS = 8'h04;
  localparam logic [7:0] CMD_OFS = 8'h08;
  localparam logic [7:0] TEST_OFS = 8'h0c;
  localparam logic [7:0] STAT_OFS = 8'h10;
  localparam logic [7:0] CHAR_OFS = 8'h14;
  localparam logic [2:0] FWD_BANK = 3'h2;
  localparam logic [2:0] REV_BANK = 3'h3;

  // Control register field positions.
  localparam int C_OP = 0;
  localparam int C_DIR = 1;
  localparam int C_MOT = 2;
  localparam int C_FWD = 3;
  localparam int C_REV = 4;
  localparam int C_TEST = 5;
  localparam int C_BCD = 6;
  localparam int C_DENS = 7;
  localparam logic [8:0] CTRL_RST = 9'h000;

  // Gap register field positions.
  localparam int G_GAP = 0;
  localparam int G_LOAD = 1;
  localparam int G_CHK = 2;
  localparam logic [2:0] GAP_RST = 3'h0;

  // Density selections; code 3 selects no timer.
  typedef enum logic [1:0] {
    DENS_A = 2'b00,
    DENS_B = 2'b01,
    DENS_C = 2'b10,
    DENS_NONE = 2'b11
  } density_t;

endpackage
